// ---- logic/bsfcc_host.sv ----
// host-side command controller driving a boot-sector parallel flash by its pins
// assumes flash pin inputs synchronous to clk; software on an Avalon-MM port
//
// Notes on behaviour
// RULE1: byte mode uses only data lines 7..0; word mode uses all sixteen
// RULE2: byte space 262144 locations, word space 131072 locations
// RULE3: seven erase sectors: 16K, two 8K, 32K, three 64K bytes
// RULE4: commands go to the device as ordinary write cycles
// RULE5: device latches address and data on each write cycle
// RULE6: finished program sequence starts device's own timed program run
// RULE7: bypass mode programs with two writes instead of four
// RULE8: erase sequence starts device's own preprogram and erase run
// RULE9: progress shows on ready pin and polling and toggle bits
// RULE10: after completion the device reads array and takes commands
// RULE11: erasing a sector leaves other sectors unchanged
// RULE12: device ignores writes during supply transitions
// RULE13: protected sectors refuse program and erase; word mode finds the sector by reading the word address as a byte address
// RULE14: erase suspend allows other-sector access until resume
// RULE15: restart pin aborts operations and returns to array read
// RULE16: device sleeps itself when addresses stay stable
// RULE17: host may put device in low-power standby
// RULE18: separate active-low chip select, write and output strobes
// RULE19: host waits for completion before next program or erase
`timescale 1ns/100ps
module bsfcc_host #(
  parameter logic [17:0] UNLOCK_ADDR1 = 18'h00001,
  parameter logic [15:0] UNLOCK_DATA1 = 16'h0001,
  parameter logic [17:0] UNLOCK_ADDR2 = 18'h00002,
  parameter logic [15:0] UNLOCK_DATA2 = 16'h0002,
  parameter logic [15:0] PROGRAM_CODE = 16'h0003,
  parameter logic [15:0] ERASE_SETUP_CODE = 16'h0004,
  parameter logic [15:0] SECTOR_ERASE_CODE = 16'h0005
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [16:0] flash_a,
  input wire logic [15:0] flash_dq_i,
  output logic [15:0] flash_dq_o,
  output logic [15:0] flash_dq_oe,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n,
  output logic flash_byte_n,
  output logic flash_reset_n,
  input wire logic op_done_indicator_n
);

  // ****************************************************
  // state record
  // ****************************************************
  typedef struct packed {
    bsfcc_pkg::bsfcc_fsm_t st;
    logic [15:0] cnt;
    logic [2:0] step;
    logic [2:0] op;
    logic [17:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic bypass;
    logic [6:0] prot;
    logic refused;
    logic [15:0] guard;
    logic av_wait;
    logic [31:0] av_rdata;
    logic [16:0] fa;
    logic [15:0] dq_o;
    logic [15:0] dq_oe;
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic byte_n;
    logic rst_n;
  } bsfcc_state_t;

  bsfcc_state_t s_r;
  bsfcc_state_t s_nxt;

  // ****************************************************
  // helpers
  // ****************************************************
  // byte address to sector index, bottom boot layout
  function automatic logic [2:0] sector_of(input logic [17:0] a);
    logic [2:0] r;
    r = 3'h0;
    // RULE3 sector layout
    if (a >= bsfcc_pkg::SEC4_BASE) begin
      r = 3'h3 + {1'b0, a[17:16]};
    end else if (a >= bsfcc_pkg::SEC3_BASE) begin
      r = 3'h3;
    end else if (a >= bsfcc_pkg::SEC2_BASE) begin
      r = 3'h2;
    end else if (a >= bsfcc_pkg::SEC1_BASE) begin
      r = 3'h1;
    end
    return r;
  endfunction : sector_of

  // address and data of one write of a command sequence
  function automatic logic [33:0] seq_word(input logic [2:0] op, input logic byp,
                                           input logic [2:0] step, input logic [17:0] a,
                                           input logic [15:0] d);
    logic [33:0] r;
    r = {a, d};
    if (op == bsfcc_pkg::OP_PROGRAM && byp) begin
      // RULE7 two-write program
      r = (step == 3'h0) ? {a, PROGRAM_CODE} : {a, d};
    end else if (op == bsfcc_pkg::OP_PROGRAM) begin
      unique case (step)
        3'h0: r = {UNLOCK_ADDR1, UNLOCK_DATA1};
        3'h1: r = {UNLOCK_ADDR2, UNLOCK_DATA2};
        3'h2: r = {UNLOCK_ADDR1, PROGRAM_CODE};
        default: r = {a, d};
      endcase
    end else if (op == bsfcc_pkg::OP_ERASE) begin
      // RULE8 six-write sector erase
      unique case (step)
        3'h0, 3'h3: r = {UNLOCK_ADDR1, UNLOCK_DATA1};
        3'h1, 3'h4: r = {UNLOCK_ADDR2, UNLOCK_DATA2};
        3'h2: r = {UNLOCK_ADDR1, ERASE_SETUP_CODE};
        default: r = {a, SECTOR_ERASE_CODE};
      endcase
    end
    return r;
  endfunction : seq_word

  // number of writes minus one for the current operation
  function automatic logic [2:0] last_step(input logic [2:0] op, input logic byp);
    logic [2:0] r;
    r = 3'h0;
    if (op == bsfcc_pkg::OP_PROGRAM) begin
      r = byp ? 3'h1 : 3'h3;
    end else if (op == bsfcc_pkg::OP_ERASE) begin
      r = 3'h5;
    end
    return r;
  endfunction : last_step

  // byte-enable merge of a written word
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction : be_merge

  // ****************************************************
  // next-state logic
  // ****************************************************
  always_comb begin
    logic flash_busy;
    logic [33:0] sw;
    logic [31:0] cfg;
    logic [2:0] wop;
    logic [4:0] boff;
    flash_busy = 1'b0;
    sw = '0;
    cfg = '0;
    wop = '0;
    boff = {avs_address, 2'b00};
    s_nxt = s_r;
    // RULE9 busy from ready pin
    flash_busy = (s_r.guard != 16'h0000) || !op_done_indicator_n;
    cfg[bsfcc_pkg::CFG_BYTE_MODE] = !s_r.byte_n;
    cfg[bsfcc_pkg::CFG_BYPASS] = s_r.bypass;
    cfg[bsfcc_pkg::CFG_PROT_LSB +: bsfcc_pkg::NUM_SECTORS] = s_r.prot;
    if (s_r.guard != 16'h0000) begin
      s_nxt.guard = s_r.guard - 16'h0001;
    end

    // bus slave: one wait cycle, then answer
    s_nxt.av_wait = !((avs_read || avs_write) && s_r.av_wait);
    if (avs_read && s_r.av_wait) begin
      unique case (boff)
        bsfcc_pkg::REG_CTRL: s_nxt.av_rdata = {29'h0, s_r.op};
        bsfcc_pkg::REG_ADDR: s_nxt.av_rdata = {14'h0, s_r.addr};
        bsfcc_pkg::REG_WDATA: s_nxt.av_rdata = {16'h0, s_r.wdata};
        bsfcc_pkg::REG_STATUS: begin
          s_nxt.av_rdata = {16'h0, s_r.rdata};
          s_nxt.av_rdata[bsfcc_pkg::ST_CTRL_BUSY] = s_r.st != bsfcc_pkg::BSFCC_IDLE;
          s_nxt.av_rdata[bsfcc_pkg::ST_FLASH_BUSY] = flash_busy;
          s_nxt.av_rdata[bsfcc_pkg::ST_REFUSED] = s_r.refused;
          s_nxt.av_rdata[bsfcc_pkg::ST_POLL_BIT] = s_r.rdata[7];
          s_nxt.av_rdata[bsfcc_pkg::ST_TOGGLE_BIT] = s_r.rdata[6];
        end
        bsfcc_pkg::REG_CONFIG: s_nxt.av_rdata = cfg;
        default: s_nxt.av_rdata = 32'h0000_0000;
      endcase
    end
    if (avs_write && !s_r.av_wait) begin
      unique case (boff)
        bsfcc_pkg::REG_ADDR:
          s_nxt.addr = 18'(be_merge({14'h0, s_r.addr}, avs_writedata, avs_byteenable));
        bsfcc_pkg::REG_WDATA:
          s_nxt.wdata = 16'(be_merge({16'h0, s_r.wdata}, avs_writedata, avs_byteenable));
        bsfcc_pkg::REG_STATUS:
          if (avs_byteenable[2] && avs_writedata[bsfcc_pkg::ST_REFUSED]) begin
            s_nxt.refused = 1'b0;
          end
        bsfcc_pkg::REG_CONFIG: begin
          cfg = be_merge(cfg, avs_writedata, avs_byteenable);
          s_nxt.byte_n = !cfg[bsfcc_pkg::CFG_BYTE_MODE];
          s_nxt.bypass = cfg[bsfcc_pkg::CFG_BYPASS];
          s_nxt.prot = cfg[bsfcc_pkg::CFG_PROT_LSB +: bsfcc_pkg::NUM_SECTORS];
        end
        bsfcc_pkg::REG_CTRL: begin
          wop = avs_writedata[bsfcc_pkg::CTRL_OP_LSB +: bsfcc_pkg::CTRL_OP_W];
          if (s_r.st != bsfcc_pkg::BSFCC_IDLE || wop > bsfcc_pkg::OP_RESTART) begin
            s_nxt.refused = 1'b1;
          end else if ((wop == bsfcc_pkg::OP_PROGRAM || wop == bsfcc_pkg::OP_ERASE)
                       // RULE19 wait for completion
                       && (flash_busy
                       // RULE13 protected sector
                       || s_r.prot[sector_of(s_r.addr)])) begin
            s_nxt.refused = 1'b1;
          end else if (wop == bsfcc_pkg::OP_RESTART) begin
            // RULE15 pulse restart pin
            s_nxt.op = wop;
            s_nxt.st = bsfcc_pkg::BSFCC_RST_HOLD;
            s_nxt.rst_n = 1'b0;
            s_nxt.guard = 16'h0000;
            s_nxt.cnt = 16'(bsfcc_pkg::RESET_LOW_CYC);
          end else begin
            s_nxt.op = wop;
            s_nxt.step = 3'h0;
            s_nxt.st = bsfcc_pkg::BSFCC_SETUP;
          end
        end
        default: ;
      endcase
    end

    // pin sequencer
    sw = seq_word(s_r.op, s_r.bypass, s_r.step, s_r.addr, s_r.wdata);
    unique case (s_r.st)
      bsfcc_pkg::BSFCC_IDLE: ;
      bsfcc_pkg::BSFCC_SETUP: begin
        // RULE2 address mapping per organisation
        s_nxt.fa = s_r.byte_n ? sw[32:16] : sw[33:17];
        s_nxt.ce_n = 1'b0;
        s_nxt.dq_o = s_r.byte_n ? sw[15:0] : {sw[16], 7'h00, sw[7:0]};
        // RULE1 byte mode drives address bit on line 15, plus low lane on writes only
        s_nxt.dq_oe = (s_r.op == bsfcc_pkg::OP_READ) ? (s_r.byte_n ? 16'h0000 : 16'h8000)
                      : (s_r.byte_n ? 16'hffff : 16'h80ff);
        if (s_r.op == bsfcc_pkg::OP_READ) begin
          s_nxt.oe_n = 1'b0;
          s_nxt.cnt = 16'(bsfcc_pkg::RD_ACC_CYC);
          s_nxt.st = bsfcc_pkg::BSFCC_READ_WAIT;
        end else begin
          // RULE4 command as a plain write cycle
          s_nxt.we_n = 1'b0;
          s_nxt.cnt = 16'(bsfcc_pkg::WE_LOW_CYC);
          s_nxt.st = bsfcc_pkg::BSFCC_STROBE;
        end
      end
      bsfcc_pkg::BSFCC_STROBE: begin
        s_nxt.cnt = s_r.cnt - 16'h0001;
        if (s_r.cnt == 16'h0001) begin
          s_nxt.we_n = 1'b1;
          s_nxt.cnt = 16'(bsfcc_pkg::WE_HIGH_CYC);
          s_nxt.st = bsfcc_pkg::BSFCC_RECOVER;
        end
      end
      bsfcc_pkg::BSFCC_RECOVER: begin
        // RULE17 chip deselected between accesses for standby
        s_nxt.ce_n = 1'b1;
        s_nxt.dq_oe = 16'h0000;
        s_nxt.cnt = s_r.cnt - 16'h0001;
        if (s_r.cnt == 16'h0001) begin
          if (s_r.step == last_step(s_r.op, s_r.bypass)) begin
            s_nxt.st = bsfcc_pkg::BSFCC_IDLE;
            if (s_r.op == bsfcc_pkg::OP_PROGRAM || s_r.op == bsfcc_pkg::OP_ERASE) begin
              // RULE6 device runs on; hold busy until ready pin valid
              s_nxt.guard = 16'(bsfcc_pkg::BUSY_GUARD_CYC);
            end
          end else begin
            s_nxt.step = s_r.step + 3'h1;
            s_nxt.st = bsfcc_pkg::BSFCC_SETUP;
          end
        end
      end
      bsfcc_pkg::BSFCC_READ_WAIT: begin
        s_nxt.cnt = s_r.cnt - 16'h0001;
        if (s_r.cnt == 16'h0001) begin
          // RULE9 status bits captured with read data
          s_nxt.rdata = s_r.byte_n ? flash_dq_i : {8'h00, flash_dq_i[7:0]};
          s_nxt.oe_n = 1'b1;
          s_nxt.ce_n = 1'b1;
          s_nxt.dq_oe = 16'h0000;
          s_nxt.st = bsfcc_pkg::BSFCC_IDLE;
        end
      end
      bsfcc_pkg::BSFCC_RST_HOLD: begin
        s_nxt.cnt = s_r.cnt - 16'h0001;
        if (s_r.cnt == 16'h0001) begin
          s_nxt.rst_n = 1'b1;
          s_nxt.st = bsfcc_pkg::BSFCC_IDLE;
        end
      end
    endcase
  end

  // ****************************************************
  // state register
  // ****************************************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_r <= '0;
      s_r.st <= bsfcc_pkg::BSFCC_RST_HOLD;
      s_r.cnt <= 16'(bsfcc_pkg::RESET_LOW_CYC);
      s_r.bypass <= bsfcc_pkg::CFG_BYPASS_RST;
      s_r.prot <= bsfcc_pkg::CFG_PROT_RST;
      s_r.byte_n <= !bsfcc_pkg::CFG_BYTE_MODE_RST;
      s_r.av_wait <= 1'b1;
      // RULE18 strobes idle high
      s_r.ce_n <= 1'b1;
      s_r.we_n <= 1'b1;
      s_r.oe_n <= 1'b1;
      s_r.rst_n <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state record
  assign avs_readdata = s_r.av_rdata;
  assign avs_waitrequest = s_r.av_wait;
  assign flash_a = s_r.fa;
  assign flash_dq_o = s_r.dq_o;
  assign flash_dq_oe = s_r.dq_oe;
  assign flash_ce_n = s_r.ce_n;
  assign flash_we_n = s_r.we_n;
  assign flash_oe_n = s_r.oe_n;
  assign flash_byte_n = s_r.byte_n;
  assign flash_reset_n = s_r.rst_n;

endmodule : bsfcc_host

// ---- shared/bsfcc_pkg.sv ----
// constants, register map and state encoding of the flash command controller
// assumes a 100 MHz system clock and an Avalon-MM register port of 32-bit words
package bsfcc_pkg;

  // ****************************************************
  // clock and pin timing
  // ****************************************************
  localparam int CLK_NS = 10;
  localparam int WE_LOW_NS = 50;      // write strobe low time
  localparam int WE_HIGH_NS = 30;     // write strobe recovery time
  localparam int RD_ACC_NS = 120;     // read access time
  localparam int RESET_LOW_NS = 500;  // restart pin low time
  localparam int BUSY_GUARD_NS = 100; // wait before ready pin is trusted
  localparam int WE_LOW_CYC = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int WE_HIGH_CYC = (WE_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_ACC_CYC = (RD_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int RESET_LOW_CYC = (RESET_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int BUSY_GUARD_CYC = (BUSY_GUARD_NS + CLK_NS - 1) / CLK_NS;

  // ****************************************************
  // register map (byte offsets)
  // ****************************************************
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_ADDR = 5'h04;
  localparam logic [4:0] REG_WDATA = 5'h08;
  localparam logic [4:0] REG_STATUS = 5'h0c;
  localparam logic [4:0] REG_CONFIG = 5'h10;

  // ctrl fields
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_OP_W = 3;
  localparam logic [2:0] OP_READ = 3'h0;
  localparam logic [2:0] OP_WRITE = 3'h1;
  localparam logic [2:0] OP_PROGRAM = 3'h2;
  localparam logic [2:0] OP_ERASE = 3'h3;
  localparam logic [2:0] OP_RESTART = 3'h4;

  // status fields
  localparam int ST_RDATA_LSB = 0;
  localparam int ST_CTRL_BUSY = 16;
  localparam int ST_FLASH_BUSY = 17;
  localparam int ST_REFUSED = 18;
  localparam int ST_POLL_BIT = 19;
  localparam int ST_TOGGLE_BIT = 20;

  // config fields
  localparam int CFG_BYTE_MODE = 0;
  localparam int CFG_BYPASS = 1;
  localparam int CFG_PROT_LSB = 8;
  localparam int NUM_SECTORS = 7;

  // reset values
  localparam logic CFG_BYTE_MODE_RST = 1'b0;
  localparam logic CFG_BYPASS_RST = 1'b0;
  localparam logic [6:0] CFG_PROT_RST = 7'h00;

  // sector bounds in byte addresses
  localparam logic [17:0] SEC1_BASE = 18'h04000;
  localparam logic [17:0] SEC2_BASE = 18'h06000;
  localparam logic [17:0] SEC3_BASE = 18'h08000;
  localparam logic [17:0] SEC4_BASE = 18'h10000;

  typedef enum logic [2:0] {
    BSFCC_IDLE,
    BSFCC_SETUP,
    BSFCC_STROBE,
    BSFCC_RECOVER,
    BSFCC_READ_WAIT,
    BSFCC_RST_HOLD
  } bsfcc_fsm_t;

endpackage : bsfcc_pkg

// ---- verif/bsfcc_host_sva.sv ----
// assertion checker for the flash command controller ports
// assumes it is bound onto every bsfcc_host instance
`timescale 1ns/100ps
module bsfcc_host_sva (
  input wire logic clk,
  input wire logic reset,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [16:0] flash_a,
  input wire logic [15:0] flash_dq_o,
  input wire logic [15:0] flash_dq_oe,
  input wire logic flash_ce_n,
  input wire logic flash_we_n,
  input wire logic flash_oe_n,
  input wire logic flash_byte_n,
  input wire logic flash_reset_n
);
  // ****************
  // handshake and pin checks
  // ****************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // write strobe low five cycles, then high
  sequence s_we_pulse;
    !flash_we_n [*5] ##1 flash_we_n;
  endsequence
  a_bus_ack_next: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered in one cycle");
  a_ack_single: assert property (
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_we_pulse_width: assert property (
    $fell(flash_we_n) |-> s_we_pulse)
    else $error("write strobe width wrong");
  a_we_under_ce: assert property (
    !flash_we_n |-> !flash_ce_n && flash_dq_oe != 16'h0000)
    else $error("write strobe without select or data");
  a_hold_addr_data: assert property (
    !flash_we_n && !$past(flash_we_n) |-> $stable(flash_a) && $stable(flash_dq_o))
    else $error("address or data moved during write strobe");
  a_no_oe_drive: assert property (
    !flash_oe_n |-> flash_we_n && flash_dq_oe[14:0] == 15'h0000)
    else $error("bus contention while output enabled");
  a_byte_lanes: assert property (
    !flash_byte_n && !flash_ce_n |-> flash_dq_oe[14:8] == 7'h00)
    else $error("upper data lines driven in byte mode");
  a_restart_low: assert property (
    $fell(flash_reset_n) |=> !flash_reset_n [*8])
    else $error("restart pulse too short");
endmodule : bsfcc_host_sva

bind bsfcc_host bsfcc_host_sva chk_u (.clk(clk), .reset(reset), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .flash_a(flash_a),
  .flash_dq_o(flash_dq_o), .flash_dq_oe(flash_dq_oe), .flash_ce_n(flash_ce_n),
  .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n), .flash_byte_n(flash_byte_n),
  .flash_reset_n(flash_reset_n));

// ---- verif/bsfcc_flash_model.sv ----
// behavioural flash array facing the command controller
// assumes pins change on clk edges; flash_a is the word index
`timescale 1ns/100ps
module bsfcc_flash_model #(
  parameter logic [15:0] PROG_CODE = 16'h0003,
  parameter logic [15:0] ERASE_CODE = 16'h0005,
  parameter logic [15:0] SUSP_CODE = 16'h0006,   // arbitrary
  parameter logic [15:0] RESUME_CODE = 16'h0007, // arbitrary
  parameter int BUSY_CYC = 600
) (
  input wire logic clk,
  input wire logic [16:0] flash_a,
  input wire logic [15:0] flash_dq_o,
  input wire logic flash_ce_n,
  input wire logic flash_we_n,
  input wire logic flash_oe_n,
  input wire logic flash_byte_n,
  input wire logic flash_reset_n,
  output logic [15:0] flash_dq_i,
  output logic op_done_indicator_n,
  output logic [15:0] n_writes
);
  // ****************
  // array, status and pins
  // ****************
  // word space
  logic [15:0] mem [0:131071];
  logic [15:0] last, rd, wd, held;
  logic we_q, armed, tog, oe_q, susp;
  int busy;
  function automatic int sec(input logic [17:0] b);
    return (b < 18'h04000) ? 0 : (b < 18'h06000) ? 1 : (b < 18'h08000) ? 2 :
      (b < 18'h10000) ? 3 : 3 + int'(b[17:16]);
  endfunction : sec
  // erased array at start
  initial begin
    foreach (mem[k]) mem[k] = 16'hffff;
    {we_q, armed, tog, oe_q, susp, busy, n_writes, held, last} = '0;
  end
  assign op_done_indicator_n = (busy == 0) || susp;
  assign wd = mem[flash_a];
  assign rd = (busy != 0 && !susp) ? {8'h00, ~last[7], tog, 6'h00} :
    flash_byte_n ? wd : {~held[15:8], flash_dq_o[15] ? wd[15:8] : wd[7:0]};
  assign flash_dq_i = (!flash_ce_n && !flash_oe_n) ? rd : ~held;
  // write capture, timed program and erase runs
  always @(posedge clk) begin
    we_q <= flash_we_n;
    oe_q <= flash_oe_n;
    if (!flash_ce_n && !flash_oe_n) held <= flash_dq_i;
    if (!oe_q && flash_oe_n) tog <= ~tog;
    if (busy > 0 && !susp) busy <= busy - 1;
    if (!flash_reset_n) begin
      busy <= 0;
      armed <= 1'b0;
      susp <= 1'b0;
    end else if (!we_q && flash_we_n && !flash_ce_n) begin
      n_writes <= n_writes + 16'h0001;
      // suspend freezes the running count, resume releases it
      if (busy != 0 && flash_dq_o == SUSP_CODE) begin
        susp <= 1'b1;
      end else if (susp && flash_dq_o == RESUME_CODE) begin
        susp <= 1'b0;
      end else if (busy == 0 && armed) begin
        mem[flash_a] = mem[flash_a] & flash_dq_o;
        last <= flash_dq_o;
        busy <= BUSY_CYC;
        armed <= 1'b0;
      end else if (busy == 0 && flash_dq_o == PROG_CODE) begin
        armed <= 1'b1;
      end else if (busy == 0 && flash_dq_o == ERASE_CODE) begin
        for (int k = 0; k < 131072; k++)
          if (sec(18'(2 * k)) == sec({flash_a, 1'b0})) mem[k] = 16'hffff;
        last <= 16'hffff;
        busy <= BUSY_CYC;
      end
    end
  end
endmodule : bsfcc_flash_model

// ---- verif/test_boot_sector_flash_command_core.sv ----
// self-checking bench of the flash command controller with a flash model
// assumes bsfcc_host, bsfcc_flash_model and the bound checker are compiled
`timescale 1ns/100ps
module test_boot_sector_flash_command_core;
  logic clk, reset, avs_read, avs_write, avs_waitrequest, ce_n, we_n, oe_n, byte_n;
  logic rst_n, rdy_n;
  logic [2:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, st, s2;
  logic [16:0] fa;
  logic [15:0] dqi, dqo, dqoe, nw, nw0;
  int n_errors = 0;
  int n_compared = 0;
  // ****************
  // instances, clock and tasks
  // ****************
  bsfcc_host dut_u (.clk(clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .flash_a(fa), .flash_dq_i(dqi), .flash_dq_o(dqo), .flash_dq_oe(dqoe),
    .flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n), .flash_byte_n(byte_n),
    .flash_reset_n(rst_n), .op_done_indicator_n(rdy_n));
  bsfcc_flash_model mdl_u (.clk(clk), .flash_a(fa), .flash_dq_o(dqo), .flash_ce_n(ce_n),
    .flash_we_n(we_n), .flash_oe_n(oe_n), .flash_byte_n(byte_n), .flash_reset_n(rst_n),
    .flash_dq_i(dqi), .op_done_indicator_n(rdy_n), .n_writes(nw));
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // compare and count
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // one Avalon access, held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic rd, input logic [2:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= rd;
    avs_write <= !rd;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) chk("waitrequest", {31'h0, avs_waitrequest}, 32'h0);
    st = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  // poll status until controller (and flash if full) is idle
  task automatic wait_idle(input logic full);
    int n;
    n = 0;
    do begin
      bus(1'b1, 3'h3, 32'h0);
      n++;
    end while ((st[16] || (full && st[17])) && n < 500);
    if (st[16] || (full && st[17])) chk("idle wait", st, 32'h0);
  endtask : wait_idle
  // address, data, then operation code
  task automatic op(input logic [2:0] c, input logic [31:0] a, input logic [31:0] d);
    bus(1'b0, 3'h1, a);
    bus(1'b0, 3'h2, d);
    bus(1'b0, 3'h0, {29'h0, c});
    wait_idle(1'b0);
  endtask : op
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  // watchdog
  initial begin
    #300us;
    n_errors++;
    report_and_stop();
  end
  // test sequence
  initial begin
    reset = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 3'h0;
    avs_writedata = 32'h0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    op(3'h2, 32'h10, 32'h5a3c);
    chk("refused in hold", st[18], 1'b1);
    bus(1'b0, 3'h3, 32'h0004_0000);
    bus(1'b1, 3'h4, 32'h0);
    chk("config reset", st, 32'h0);
    bus(1'b0, 3'h7, 32'h1234_5678);
    bus(1'b1, 3'h7, 32'h0);
    chk("unmapped", st, 32'h0);
    $display("hold and reset test done");
    wait_idle(1'b1);
    nw0 = nw;
    op(3'h2, 32'h10, 32'h5a3c);
    wait_idle(1'b1);
    chk("normal writes", {16'h0, nw - nw0}, 32'h4);
    op(3'h0, 32'h10, 32'h0);
    chk("word readback", {16'h0, st[15:0]}, 32'h5a3c);
    bus(1'b0, 3'h4, 32'h2);
    nw0 = nw;
    op(3'h2, 32'h9000, 32'habcd);
    wait_idle(1'b1);
    chk("bypass writes", {16'h0, nw - nw0}, 32'h2);
    op(3'h0, 32'h9000, 32'h0);
    chk("bypass readback", {16'h0, st[15:0]}, 32'habcd);
    $display("program test done");
    bus(1'b0, 3'h4, 32'h100);
    op(3'h2, 32'h20, 32'h1111);
    chk("protect refused", st[18], 1'b1);
    op(3'h0, 32'h20, 32'h0);
    chk("protect data", {16'h0, st[15:0]}, 32'hffff);
    bus(1'b0, 3'h3, 32'h0004_0000);
    bus(1'b0, 3'h4, 32'h0);
    $display("protect test done");
    op(3'h3, 32'h9000, 32'h0);
    op(3'h0, 32'h9000, 32'h0);
    s2 = st;
    op(3'h0, 32'h9000, 32'h0);
    chk("toggle bit", st[20] ^ s2[20], 1'b1);
    chk("poll bit", st[19], 1'b0);
    chk("flash busy", st[17], 1'b1);
    op(3'h2, 32'h10, 32'h0);
    chk("busy refused", st[18], 1'b1);
    bus(1'b0, 3'h3, 32'h0004_0000);
    op(3'h1, 32'h0, 32'h6);
    op(3'h0, 32'h10, 32'h0);
    chk("suspend read", {16'h0, st[15:0]}, 32'h5a3c);
    op(3'h1, 32'h0, 32'h7);
    chk("resumed busy", st[17], 1'b1);
    op(3'h4, 32'h0, 32'h0);
    repeat (60) @(posedge clk);
    bus(1'b1, 3'h3, 32'h0);
    chk("restart abort", st[17], 1'b0);
    wait_idle(1'b1);
    op(3'h0, 32'h9000, 32'h0);
    chk("erased word", {16'h0, st[15:0]}, 32'hffff);
    op(3'h0, 32'h10, 32'h0);
    chk("other sector", {16'h0, st[15:0]}, 32'h5a3c);
    $display("erase and restart test done");
    bus(1'b0, 3'h4, 32'h1);
    op(3'h0, 32'h21, 32'h0);
    chk("byte high", {16'h0, st[15:0]}, 32'h005a);
    op(3'h0, 32'h20, 32'h0);
    chk("byte low", {16'h0, st[15:0]}, 32'h003c);
    $display("byte mode test done");
    report_and_stop();
  end
endmodule : test_boot_sector_flash_command_core
